//--- ebs_cpu_model.sv
`timescale 1ns/1ps

module ebs_cpu_model
  import ebs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input ebs_pkg::ebs_cpu_ctrl_type cpu_ctrl,
  input wire logic [2:0] retire_delay,
  input wire logic trap_on,
  input wire logic [ebs_pkg::ADDR_W-1:0] trap_addr,
  output logic issue_req,
  output logic [ebs_pkg::ADDR_W-1:0] issue_addr,
  output logic issue_is_trap,
  output logic retire
);
  import ebs_pkg::*;

  logic [ADDR_W-1:0] pc;
  logic [3:0] busy;

  // ----------------------------------------------------------------
  // pipeline front end
  // ----------------------------------------------------------------
  // request held until the grant is seen, then retire after a chosen delay
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      pc <= '0;
      busy <= 4'h0;
      issue_req <= 1'b0;
      retire <= 1'b0;
    end
    else
    begin
      retire <= 1'b0;
      if (cpu_ctrl.pc_load)
      begin
        pc <= cpu_ctrl.pc_value;
        busy <= 4'h0;
        issue_req <= 1'b0;
      end
      else if (cpu_ctrl.issue_grant)
      begin
        // request dropped at the edge that saw the grant, or by a pc load
        issue_req <= 1'b0;
        pc <= pc + 32'h4;
        busy <= {1'b0, retire_delay} + 4'h1;
      end
      else if (busy != 4'h0)
      begin
        busy <= busy - 4'h1;
        retire <= (busy == 4'h1);
      end
      else
      begin
        issue_req <= 1'b1;
      end
    end
  end

  // released address bus shows garbage, not the last value
  assign issue_addr = issue_req ? pc : ~pc;
  // substituted trap instruction at the chosen address
  assign issue_is_trap = issue_req && trap_on && (pc == trap_addr);
endmodule // ebs_cpu_model

//--- ebs_fail_safe.sv
`timescale 1ns/1ps

module ebs_fail_safe
  import ebs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input ebs_pkg::ebs_access_type acc,
  input ebs_pkg::ebs_map_type map,
  input ebs_pkg::ebs_io_attr_type io_attr,
  output logic violation
);

  // ----------------------------------------------------------------
  // region decode and illegal access checks
  // ----------------------------------------------------------------
  logic in_rom;
  logic in_ram;
  logic in_io;

  // plain range compares; overlapping regions are the mapper's problem
  always_comb
  begin
    in_rom = (acc.addr >= map.rom_lo) && (acc.addr <= map.rom_hi);
    in_ram = (acc.addr >= map.ram_lo) && (acc.addr <= map.ram_hi);
    in_io = (acc.addr >= map.io_lo) && (acc.addr <= map.io_hi);
    violation = 1'b0;
    if (acc.valid)
    begin
      if (!in_rom && !in_ram && !in_io)
        violation = 1'b1;
      if (in_rom && acc.kind == ACC_WRITE)
        violation = 1'b1;
      if (in_io && acc.kind != ACC_FETCH && !io_attr.width_mask[acc.size])
        violation = 1'b1;
      if (in_io && acc.kind == ACC_WRITE && io_attr.read_only)
        violation = 1'b1;
      if (in_io && acc.kind == ACC_READ && io_attr.write_only)
        violation = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_rom_write_flag: assert property (@(posedge clk_sys) disable iff (reset)
    acc.valid && acc.kind == ACC_WRITE && in_rom |-> violation)
    else $error("rom write not flagged");

  a_io_width_flag: assert property (@(posedge clk_sys) disable iff (reset)
    acc.valid && in_io && acc.kind == ACC_READ && !io_attr.width_mask[acc.size] |-> violation)
    else $error("bad io width not flagged");

endmodule // ebs_fail_safe

//--- ebs_interval_timer.sv
`timescale 1ns/1ps

module ebs_interval_timer
  import ebs_pkg::*;
#(
  parameter int WIDTH = TIMER_W,
  parameter logic [TIMER_W-1:0] LIMIT_DEFAULT = TIMER_W'(OVF_EXAMPLE_CYCLES)
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic enable,
  input wire logic start_evt,
  input wire logic end_evt,
  input wire logic [WIDTH-1:0] limit,
  output logic overflow
);

  typedef struct packed
  {
    logic measuring;
    logic [WIDTH-1:0] count;
    logic ovf;
  } ebs_timer_state_type;

  ebs_timer_state_type cur;
  ebs_timer_state_type next_cur;
  logic [WIDTH-1:0] eff_limit;

  // ----------------------------------------------------------------
  // interval measurement
  // ----------------------------------------------------------------
  // a zero limit falls back to the default so a cleared limit never fires at once
  always_comb
  begin
    eff_limit = (limit == '0) ? LIMIT_DEFAULT[WIDTH-1:0] : limit;
    next_cur = cur;
    next_cur.ovf = 1'b0;
    if (!enable)
    begin
      next_cur.measuring = 1'b0;
      next_cur.count = '0;
    end
    else if (!cur.measuring)
    begin
      if (start_evt)
      begin
        next_cur.measuring = 1'b1;
        next_cur.count = '0;
      end
    end
    else if (end_evt)
      next_cur.measuring = 1'b0;
    else if (cur.count + WIDTH'(1) >= eff_limit)
    begin
      next_cur.ovf = 1'b1;
      next_cur.measuring = 1'b0;
    end
    else
      next_cur.count = cur.count + WIDTH'(1);
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      cur <= '0;
    else
      cur <= next_cur;
  end

  assign overflow = cur.ovf;

  a_ovf_at_limit: assert property (@(posedge clk_sys) disable iff (reset)
    enable && cur.measuring && !end_evt && cur.count + WIDTH'(1) >= eff_limit |=> overflow)
    else $error("overflow missed at limit");

endmodule // ebs_interval_timer

//--- ebs_pkg.sv
package ebs_pkg;

  // ----------------------------------------------------------------
  // widths and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int TIMER_W = 32;
  localparam int NUM_EXEC_POINTS = 2;
  localparam int CLK_PERIOD_NS = 8;
  // example overflow limit in its own unit, then in clock cycles
  localparam int OVF_EXAMPLE_MS = 2;
  localparam int NS_PER_MS = 1000000;
  localparam int OVF_EXAMPLE_CYCLES = (OVF_EXAMPLE_MS * NS_PER_MS) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_HALT = 3'b000,
    ST_LOAD_RUN = 3'b001,
    ST_LOAD_STEP = 3'b010,
    ST_RUN = 3'b011,
    ST_STEP_ISSUE = 3'b100,
    ST_STEP_WAIT = 3'b101
  } ebs_state_type;

  typedef enum logic [2:0]
  {
    CAUSE_NONE = 3'b000,
    CAUSE_HW = 3'b001,
    CAUSE_SW = 3'b010,
    CAUSE_FAILSAFE = 3'b011,
    CAUSE_TIMER = 3'b100,
    CAUSE_FORCED = 3'b101,
    CAUSE_STEP = 3'b110
  } ebs_cause_type;

  typedef enum logic [1:0]
  {
    ACC_FETCH = 2'b00,
    ACC_READ = 2'b01,
    ACC_WRITE = 2'b10
  } ebs_kind_type;

  // access size doubles as the bit index into the width mask
  typedef enum logic [1:0]
  {
    SIZE_8 = 2'b00,
    SIZE_16 = 2'b01,
    SIZE_32 = 2'b10
  } ebs_size_type;

  // timer start/end event selectors
  localparam logic [1:0] EVT_EXEC0 = 2'h0;
  localparam logic [1:0] EVT_EXEC1 = 2'h1;
  localparam logic [1:0] EVT_DATA = 2'h2;
  localparam logic [1:0] EVT_RUN = 2'h3;
  localparam int NUM_EVENTS = 4;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic valid;
    ebs_kind_type kind;
    ebs_size_type size;
    logic [ADDR_W-1:0] addr;
  } ebs_access_type;

  typedef struct packed
  {
    logic [ADDR_W-1:0] rom_lo;
    logic [ADDR_W-1:0] rom_hi;
    logic [ADDR_W-1:0] ram_lo;
    logic [ADDR_W-1:0] ram_hi;
    logic [ADDR_W-1:0] io_lo;
    logic [ADDR_W-1:0] io_hi;
  } ebs_map_type;

  typedef struct packed
  {
    logic [2:0] width_mask;
    logic read_only;
    logic write_only;
  } ebs_io_attr_type;

  typedef struct packed
  {
    logic [NUM_EXEC_POINTS-1:0] exec_en;
    logic [NUM_EXEC_POINTS-1:0][ADDR_W-1:0] exec_addr;
    logic data_en;
    logic data_on_read;
    logic data_on_write;
    logic [ADDR_W-1:0] data_addr;
  } ebs_hwbp_type;

  typedef struct packed
  {
    logic issue_grant;
    logic pc_load;
    logic [ADDR_W-1:0] pc_value;
    logic int_enable;
    logic debug_mode;
    logic periph_halt;
  } ebs_cpu_ctrl_type;

endpackage

//--- ebs_run_ctrl.sv
// What this block does
// - go starts execution at host-chosen address
// - step runs one instruction, interrupts masked
// - cpu keeps running monitor during break
// - peripherals run unless periph_stop_enable is set, interrupts pend during break
// - hardware breakpoints watch fetch and data accesses
// - data breaks halt after the accessing instruction
// - debug trap instruction halts the program
// - unmapped fetch, read or write breaks
// - any write into rom breaks
// - wrong width peripheral register access breaks
// - write read-only, read write-only register breaks
// - interval reaching programmed limit breaks
// - host forced break always stops program
// - interval start and end events are selectable
// - two pre-execution address points
`timescale 1ns/1ps

module ebs_run_ctrl
  import ebs_pkg::*;
#(
  parameter int TW = TIMER_W,
  parameter logic [TIMER_W-1:0] OVF_LIMIT_DEFAULT = TIMER_W'(OVF_EXAMPLE_CYCLES)
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic host_go,
  input wire logic host_step,
  input wire logic host_force_break,
  input wire logic [ebs_pkg::ADDR_W-1:0] host_start_addr,
  input wire logic periph_stop_enable,
  input ebs_pkg::ebs_hwbp_type hw_bp,
  input ebs_pkg::ebs_map_type mem_map,
  input wire logic timer_enable,
  input wire logic [1:0] timer_start_sel,
  input wire logic [1:0] timer_end_sel,
  input wire logic [TW-1:0] timer_limit,
  input wire logic cpu_issue_req,
  input wire logic [ebs_pkg::ADDR_W-1:0] cpu_issue_addr,
  input wire logic cpu_issue_is_trap,
  input wire logic cpu_retire,
  input ebs_pkg::ebs_access_type cpu_mem,
  input ebs_pkg::ebs_io_attr_type cpu_io_attr,
  output ebs_pkg::ebs_cpu_ctrl_type cpu_ctrl,
  output logic break_active,
  output ebs_pkg::ebs_cause_type break_cause,
  output logic break_event
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed
  {
    ebs_state_type state;
    ebs_cause_type cause;
    logic brk_pulse;
    ebs_cpu_ctrl_type ctrl;
  } ebs_ctrl_state_type;

  ebs_ctrl_state_type cur;
  ebs_ctrl_state_type next_cur;

  logic [NUM_EXEC_POINTS-1:0] exec_hit;
  logic data_hit;
  logic issue_pending;
  logic fs_fetch;
  logic fs_mem;
  logic timer_ovf;
  logic [NUM_EVENTS-1:0] events;
  ebs_access_type fetch_acc;
  ebs_cause_type late_cause;
  ebs_cause_type early_cause;

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  // a request seen in its own grant cycle is the one just granted, not a new one
  always_comb
  begin
    issue_pending = cpu_issue_req && !cur.ctrl.issue_grant;
    for (int i = 0; i < NUM_EXEC_POINTS; i++)
      exec_hit[i] = issue_pending && hw_bp.exec_en[i] && (cpu_issue_addr == hw_bp.exec_addr[i]);
    data_hit = cpu_mem.valid && hw_bp.data_en && (cpu_mem.addr == hw_bp.data_addr) &&
               ((cpu_mem.kind == ACC_READ && hw_bp.data_on_read) ||
                (cpu_mem.kind == ACC_WRITE && hw_bp.data_on_write));
    fetch_acc.valid = issue_pending;
    fetch_acc.kind = ACC_FETCH;
    fetch_acc.size = SIZE_32;
    fetch_acc.addr = cpu_issue_addr;
    events = '0;
    events[EVT_EXEC0] = exec_hit[0];
    events[EVT_EXEC1] = exec_hit[1];
    events[EVT_DATA] = data_hit;
    events[EVT_RUN] = (cur.state == ST_LOAD_RUN);
  end

  // ----------------------------------------------------------------
  // fail-safe checkers, one on fetch and one on the memory stage
  // ----------------------------------------------------------------
  ebs_fail_safe u_fs_fetch
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .acc(fetch_acc),
    .map(mem_map),
    .io_attr(cpu_io_attr),
    .violation(fs_fetch)
  );

  ebs_fail_safe u_fs_mem
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .acc(cpu_mem),
    .map(mem_map),
    .io_attr(cpu_io_attr),
    .violation(fs_mem)
  );

  // ----------------------------------------------------------------
  // timer overflow source
  // ----------------------------------------------------------------
  ebs_interval_timer #(
    .WIDTH(TW),
    .LIMIT_DEFAULT(OVF_LIMIT_DEFAULT)
  ) u_timer
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .enable(timer_enable),
    .start_evt(events[timer_start_sel]),
    .end_evt(events[timer_end_sel]),
    .limit(timer_limit),
    .overflow(timer_ovf)
  );

  // ----------------------------------------------------------------
  // break prioritisation
  // ----------------------------------------------------------------
  // late causes belong to an instruction already granted, so they halt after it
  always_comb
  begin
    late_cause = CAUSE_NONE;
    if (host_force_break)
      late_cause = CAUSE_FORCED;
    else if (fs_mem)
      late_cause = CAUSE_FAILSAFE;
    else if (data_hit)
      late_cause = CAUSE_HW;
    early_cause = late_cause;
    if (late_cause == CAUSE_NONE)
    begin
      if (issue_pending && fs_fetch)
        early_cause = CAUSE_FAILSAFE;
      else if (issue_pending && cpu_issue_is_trap)
        early_cause = CAUSE_SW;
      else if (exec_hit != '0)
        early_cause = CAUSE_HW;
      else if (timer_ovf)
        early_cause = CAUSE_TIMER;
    end
  end

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  always_comb
  begin
    next_cur = cur;
    next_cur.ctrl.issue_grant = 1'b0;
    next_cur.ctrl.pc_load = 1'b0;
    next_cur.brk_pulse = 1'b0;
    case (cur.state)
      ST_HALT:
      begin
        // monitor keeps the core alive; interrupts stay pending
        next_cur.ctrl.debug_mode = 1'b1;
        next_cur.ctrl.int_enable = 1'b0;
        next_cur.ctrl.periph_halt = periph_stop_enable;
        if (host_go || host_step)
        begin
          next_cur.ctrl.pc_load = 1'b1;
          next_cur.ctrl.pc_value = host_start_addr;
          next_cur.cause = CAUSE_NONE;
          next_cur.state = host_go ? ST_LOAD_RUN : ST_LOAD_STEP;
        end
      end
      ST_LOAD_RUN:
      begin
        next_cur.ctrl.debug_mode = 1'b0;
        next_cur.ctrl.periph_halt = 1'b0;
        next_cur.ctrl.int_enable = 1'b1;
        next_cur.state = ST_RUN;
      end
      ST_LOAD_STEP:
      begin
        next_cur.ctrl.debug_mode = 1'b0;
        next_cur.ctrl.periph_halt = 1'b0;
        next_cur.ctrl.int_enable = 1'b0;
        next_cur.state = ST_STEP_ISSUE;
      end
      ST_RUN:
      begin
        if (early_cause != CAUSE_NONE)
        begin
          next_cur.state = ST_HALT;
          next_cur.cause = early_cause;
        end
        else if (issue_pending)
          next_cur.ctrl.issue_grant = 1'b1;
      end
      ST_STEP_ISSUE:
      begin
        if (early_cause != CAUSE_NONE)
        begin
          next_cur.state = ST_HALT;
          next_cur.cause = early_cause;
        end
        else if (issue_pending)
        begin
          next_cur.ctrl.issue_grant = 1'b1;
          next_cur.state = ST_STEP_WAIT;
        end
      end
      ST_STEP_WAIT:
      begin
        // no further grant here: exactly one instruction per step
        if (late_cause != CAUSE_NONE)
        begin
          next_cur.state = ST_HALT;
          next_cur.cause = late_cause;
        end
        else if (cpu_retire)
        begin
          next_cur.state = ST_HALT;
          next_cur.cause = CAUSE_STEP;
        end
      end
      default:
      begin
        next_cur.state = ST_HALT;
      end
    endcase
    // a forced request wins in every non-halt state, the load cycles too
    if (host_force_break && cur.state != ST_HALT)
    begin
      next_cur.state = ST_HALT;
      next_cur.cause = CAUSE_FORCED;
    end
    // entering a break: same cycle the monitor takes over
    if (next_cur.state == ST_HALT && cur.state != ST_HALT)
    begin
      next_cur.brk_pulse = 1'b1;
      next_cur.ctrl.debug_mode = 1'b1;
      next_cur.ctrl.int_enable = 1'b0;
      next_cur.ctrl.periph_halt = periph_stop_enable;
    end
  end

  // reset leaves the target halted in the monitor
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cur <= '0;
      cur.ctrl.debug_mode <= 1'b1;
    end
    else
      cur <= next_cur;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cpu_ctrl = cur.ctrl;
  assign break_active = cur.ctrl.debug_mode;
  assign break_cause = cur.cause;
  assign break_event = cur.brk_pulse;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  logic [1:0] step_grants;

  // helper: grants issued since the step was launched
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      step_grants <= 2'h0;
    else if (cur.state == ST_LOAD_STEP)
      step_grants <= 2'h0;
    else if (cur.ctrl.issue_grant && cur.state == ST_STEP_WAIT && step_grants != 2'h3)
      step_grants <= step_grants + 2'h1;
  end

  sequence go_request;
    cur.state == ST_HALT && host_go;
  endsequence

  sequence load_then_run;
    cur.ctrl.pc_load && cur.ctrl.pc_value == $past(host_start_addr) ##1 cur.state == ST_RUN && cur.ctrl.int_enable;
  endsequence

  sequence halt_two_cycles;
    cur.state == ST_HALT ##1 cur.state == ST_HALT;
  endsequence

  a_go_start_addr: assert property (go_request |=> load_then_run)
    else $error("go did not load start address and run");

  a_step_one_grant: assert property (step_grants <= 2'h1)
    else $error("more than one instruction per step");

  a_step_int_mask: assert property (
    cur.state inside {ST_STEP_ISSUE, ST_STEP_WAIT} |-> !cur.ctrl.int_enable)
    else $error("interrupts enabled while stepping");

  a_break_monitor_on: assert property (
    cur.state == ST_HALT |-> cur.ctrl.debug_mode && !cur.ctrl.int_enable)
    else $error("break without monitor or with interrupts");

  a_break_periph: assert property (halt_two_cycles |-> cur.ctrl.periph_halt == $past(periph_stop_enable))
    else $error("peripheral stop does not follow setting");

  a_exec_point_halt: assert property (
    cur.state == ST_RUN && exec_hit != '0 |=> cur.state == ST_HALT && !cur.ctrl.issue_grant)
    else $error("execution point did not halt before execution");

  a_data_break_after: assert property (
    cur.state == ST_RUN && data_hit && !host_force_break && !fs_mem |=>
    cur.state == ST_HALT && cur.cause == CAUSE_HW && cur.brk_pulse)
    else $error("data break not taken");

  a_trap_halts: assert property (
    cur.state == ST_RUN && issue_pending && cpu_issue_is_trap |=> cur.state == ST_HALT && !cur.ctrl.issue_grant)
    else $error("trap instruction was granted");

  a_failsafe_cause: assert property (
    cur.state == ST_RUN && fs_mem && !host_force_break |=> cur.cause == CAUSE_FAILSAFE)
    else $error("illegal access not recorded");

  a_timer_halt: assert property (
    cur.state == ST_RUN && timer_ovf |=> cur.state == ST_HALT)
    else $error("timer overflow did not halt");

  a_forced_halt: assert property (
    cur.state != ST_HALT && host_force_break |=> cur.state == ST_HALT && cur.cause == CAUSE_FORCED)
    else $error("forced break not taken");

  a_cause_kept: assert property (
    halt_two_cycles ##0 (!host_go && !host_step) |=> $stable(cur.cause))
    else $error("cause changed during break");

endmodule // ebs_run_ctrl

//--- ebs_run_ctrl_tb.sv
`timescale 1ns/1ps

`define ebs_check(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; $display("unexpected at %0t ns: got %0h expected %0h", $time, (got), (exp)); end end

module ebs_run_ctrl_tb;
  import ebs_pkg::*;

  localparam logic [TIMER_W-1:0] LIM = 32'h14;

  logic clk_sys, reset, host_go, host_step, host_force_break, periph_stop_enable, timer_enable;
  logic [ADDR_W-1:0] host_start_addr, issue_addr, trap_addr;
  logic [1:0] timer_start_sel, timer_end_sel;
  logic [TIMER_W-1:0] timer_limit;
  logic issue_req, issue_is_trap, retire, trap_on, break_active, break_event;
  logic [2:0] retire_delay;
  ebs_hwbp_type hw_bp;
  ebs_map_type mem_map;
  ebs_access_type cpu_mem;
  ebs_io_attr_type cpu_io_attr;
  ebs_cpu_ctrl_type cpu_ctrl;
  ebs_cause_type break_cause;
  int err_count = 0;
  int checks = 0;
  int grants = 0;
  logic int_seen;

  ebs_run_ctrl #(.OVF_LIMIT_DEFAULT(LIM)) ebs_run_ctrl_i (.clk_sys(clk_sys), .reset(reset), .host_go(host_go),
    .host_step(host_step), .host_force_break(host_force_break), .host_start_addr(host_start_addr),
    .periph_stop_enable(periph_stop_enable), .hw_bp(hw_bp), .mem_map(mem_map), .timer_enable(timer_enable),
    .timer_start_sel(timer_start_sel), .timer_end_sel(timer_end_sel), .timer_limit(timer_limit),
    .cpu_issue_req(issue_req), .cpu_issue_addr(issue_addr), .cpu_issue_is_trap(issue_is_trap),
    .cpu_retire(retire), .cpu_mem(cpu_mem), .cpu_io_attr(cpu_io_attr), .cpu_ctrl(cpu_ctrl),
    .break_active(break_active), .break_cause(break_cause), .break_event(break_event));

  ebs_cpu_model ebs_cpu_model_i (.clk_sys(clk_sys), .reset(reset), .cpu_ctrl(cpu_ctrl),
    .retire_delay(retire_delay), .trap_on(trap_on), .trap_addr(trap_addr), .issue_req(issue_req),
    .issue_addr(issue_addr), .issue_is_trap(issue_is_trap), .retire(retire));

  // ----------------------------------------------------------------
  // clock, monitors and closing
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // grant and interrupt-enable watchers, cleared by the scenarios; mid-cycle, where outputs are settled
  always @(negedge clk_sys)
  begin
    if (cpu_ctrl.issue_grant === 1'b1)
      grants++;
    if (cpu_ctrl.int_enable === 1'b1)
      int_seen = 1'b1;
  end

  task automatic complete_run();
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // whole run is well under 3000 cycles
  initial
  begin
    #200000;
    err_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // shared steps
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask

  // start or step from a chosen address; both are taken only in halt
  task automatic go(input logic [ADDR_W-1:0] addr, input logic step);
    host_start_addr = addr;
    host_go = !step;
    host_step = step;
    tick(1);
    host_go = 1'b0;
    host_step = 1'b0;
    `ebs_check(cpu_ctrl.pc_load, 1'b1)
    `ebs_check(cpu_ctrl.pc_value, addr)
    tick(1);
    `ebs_check(cpu_ctrl.debug_mode, 1'b0)
    `ebs_check(cpu_ctrl.int_enable, !step)
  endtask

  // bounded wait; a missing break shows up in the cause compare
  task automatic wait_brk(output int n);
    n = 0;
    while (break_event !== 1'b1 && n < 400)
    begin
      tick(1);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `ebs_check(break_active, 1'b1)
    `ebs_check(break_cause, CAUSE_NONE)
    `ebs_check(cpu_ctrl.int_enable, 1'b0)
  endtask

  task automatic t_forced();
    go(32'h0000_0100, 1'b0);
    tick(3);
    host_force_break = 1'b1;
    tick(1);
    host_force_break = 1'b0;
    `ebs_check(break_event, 1'b1)
    `ebs_check(break_cause, CAUSE_FORCED)
    `ebs_check(cpu_ctrl.int_enable, 1'b0)
    `ebs_check(cpu_ctrl.periph_halt, 1'b0)
    grants = 0;
    tick(5);
    `ebs_check(break_event, 1'b0)
    `ebs_check(grants, 0)
    `ebs_check(cpu_ctrl.debug_mode, 1'b1)
    `ebs_check(break_cause, CAUSE_FORCED)
  endtask

  // two back-to-back steps with a slow retire
  task automatic t_step();
    int n;
    retire_delay = 3'h3;
    for (int i = 0; i < 2; i++)
    begin
      go(32'h0000_0200 + 32'(i * 4), 1'b1);
      grants = 0;
      int_seen = 1'b0;
      wait_brk(n);
      tick(4);
      `ebs_check(break_cause, CAUSE_STEP)
      `ebs_check(grants, 1)
      `ebs_check(int_seen, 1'b0)
    end
  endtask

  // each pre-execution point halts before the third instruction
  task automatic t_exec_hit();
    int n;
    retire_delay = 3'h0;
    for (int i = 0; i < NUM_EXEC_POINTS; i++)
    begin
      hw_bp.exec_en = 2'(1 << i);
      hw_bp.exec_addr[i] = 32'h0000_0108;
      grants = 0;
      go(32'h0000_0100, 1'b0);
      wait_brk(n);
      `ebs_check(break_cause, CAUSE_HW)
      `ebs_check(grants, 2)
    end
    hw_bp.exec_en = '0;
  endtask

  // trap placed on the second instruction in rom, so one grant before the halt
  task automatic t_trap();
    int n;
    trap_on = 1'b1;
    trap_addr = 32'h0000_0204;
    grants = 0;
    go(32'h0000_0200, 1'b0);
    wait_brk(n);
    `ebs_check(break_cause, CAUSE_SW)
    `ebs_check(grants, 1)
    trap_on = 1'b0;
    // fetch from an unmapped address halts before it is granted
    go(32'h0800_0000, 1'b0);
    wait_brk(n);
    `ebs_check(break_cause, CAUSE_FAILSAFE)
  endtask

  // one illegal or watched access per run; the last one is legal
  task automatic t_access();
    ebs_access_type a [9];
    ebs_io_attr_type io [9];
    ebs_cause_type exp [9];
    a[0] = '{1'b1, ACC_WRITE, SIZE_32, 32'h0000_0400};
    a[1] = '{1'b1, ACC_READ, SIZE_32, 32'h0800_0000};
    a[2] = '{1'b1, ACC_WRITE, SIZE_8, 32'h0800_0000};
    a[3] = '{1'b1, ACC_FETCH, SIZE_32, 32'h0800_0000};
    a[4] = '{1'b1, ACC_READ, SIZE_16, 32'h0fff_0010};
    a[5] = '{1'b1, ACC_WRITE, SIZE_8, 32'h0fff_0010};
    a[6] = '{1'b1, ACC_READ, SIZE_8, 32'h0fff_0010};
    a[7] = '{1'b1, ACC_READ, SIZE_32, 32'h0300_0040};
    a[8] = '{1'b1, ACC_READ, SIZE_8, 32'h0fff_0010};
    io = '{'0, '0, '0, '0, 5'b001_0_0, 5'b001_1_0, 5'b001_0_1, '0, 5'b001_0_0};
    exp = '{CAUSE_FAILSAFE, CAUSE_FAILSAFE, CAUSE_FAILSAFE, CAUSE_FAILSAFE, CAUSE_FAILSAFE,
      CAUSE_FAILSAFE, CAUSE_FAILSAFE, CAUSE_HW, CAUSE_NONE};
    periph_stop_enable = 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      go(32'h0000_0300, 1'b0);
      tick(2);
      cpu_mem = a[i];
      cpu_io_attr = io[i];
      tick(1);
      cpu_mem = '0;
      cpu_io_attr = '0;
      `ebs_check(break_event, (exp[i] != CAUSE_NONE))
      `ebs_check(break_cause, exp[i])
      `ebs_check(cpu_ctrl.periph_halt, (exp[i] != CAUSE_NONE))
      host_force_break = 1'b1;
      tick(1);
      host_force_break = 1'b0;
    end
    periph_stop_enable = 1'b0;
  endtask

  // measurement starts at run start and never ends, so the limit trips; default limit, then a set one
  task automatic t_timer();
    int n;
    int lim;
    timer_enable = 1'b1;
    timer_start_sel = EVT_RUN;
    timer_end_sel = EVT_DATA;
    retire_delay = 3'h1;
    for (int i = 0; i < 2; i++)
    begin
      timer_limit = (i == 0) ? '0 : 32'h10;
      lim = (i == 0) ? int'(LIM) : 16;
      go(32'h0000_0500, 1'b0);
      wait_brk(n);
      `ebs_check(break_cause, CAUSE_TIMER)
      `ebs_check((n >= lim - 2) && (n <= lim + 4), 1'b1)
    end
    timer_limit = '0;
    timer_enable = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    {host_go, host_step, host_force_break, periph_stop_enable, timer_enable, trap_on} = '0;
    host_start_addr = '0;
    trap_addr = '0;
    retire_delay = 3'h0;
    timer_start_sel = 2'h0;
    timer_end_sel = 2'h0;
    timer_limit = '0;
    cpu_mem = '0;
    cpu_io_attr = '0;
    hw_bp = '0;
    hw_bp.data_en = 1'b1;
    hw_bp.data_on_read = 1'b1;
    hw_bp.data_addr = 32'h0300_0040;
    mem_map = '{32'h0000_0000, 32'h000f_ffff, 32'h0300_0000, 32'h0300_ffff, 32'h0fff_0000, 32'h0fff_ffff};
    repeat (2) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    t_reset();
    t_forced();
    t_step();
    t_exec_hit();
    t_trap();
    t_access();
    t_timer();
    complete_run();
  end
endmodule // ebs_run_ctrl_tb
